// >>> hdl/ofd_decoder.sv
// Opcode field decoder: sizes, conditions, short field, selectors, undefined traps
`timescale 1ns/1ps
module ofd_decoder
    import ofd_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Fields from the prefetch path
    input  wire logic        INSTR_VALID,
    input  wire logic [2:0]  INSTR_GROUP,
    input  wire logic [3:0]  INSTR_OPCODE,
    input  wire logic [3:0]  SHORT_FIELD,
    input  wire logic [3:0]  COND_FIELD,
    input  wire logic [1:0]  INT_SIZE,
    input  wire logic        FLOAT_TYPE,
    input  wire logic        CUSTOM_TYPE,
    input  wire logic [4:0]  FLAGS_ZCLNF,
    // Decoded results to execution
    output logic             DEC_VALID,
    output logic             EXEC_ENABLE,
    output logic [1:0]       INT_WIDTH,
    output logic [1:0]       FLOAT_WIDTH,
    output logic [1:0]       CUSTOM_WIDTH,
    output logic             COND_TRUE,
    output logic [1:0]       SHORT_ROLE,
    output logic [31:0]      QUICK_VALUE,
    output logic [3:0]       REG_SELECT,
    output logic             REG_RESERVED,
    // Exception logic
    output logic             ILLEGAL_OPCODE_TRAP,
    // Register port
    input  wire logic [1:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    output logic             IRQ
);

    logic        z_f, c_f, l_f, n_f, g_f;
    logic        cond_d, cond_q;
    logic [3:0]  cond_sel;
    logic        trap_d, trap_q;
    logic        rsvd_d, rsvd_q;
    logic [1:0]  iw_d, iw_q, fw_d, fw_q, cw_d, cw_q, role_d, role_q;
    logic [31:0] quick_d, quick_q;
    logic [3:0]  sel_d, sel_q;
    logic        valid_d, valid_q;
    logic [1:0]  stat_d, stat_q, mask_d, mask_q;
    logic [15:0] cnt_d, cnt_q;
    logic [31:0] rdata_d, rdata_q;

    assign {z_f, c_f, l_f, n_f, g_f} = FLAGS_ZCLNF;
    // Set-on-condition takes its code from the short field
    assign cond_sel = (INSTR_GROUP == GRP_SETCOND) ? SHORT_FIELD : COND_FIELD;

    always_comb begin
        case (cond_sel)
            4'h0: cond_d = z_f;
            4'h1: cond_d = !z_f;
            4'h2: cond_d = c_f;
            4'h3: cond_d = !c_f;
            4'h4: cond_d = l_f;
            4'h5: cond_d = !l_f;
            4'h6: cond_d = n_f;
            4'h7: cond_d = !n_f;
            4'h8: cond_d = g_f;
            4'h9: cond_d = !g_f;
            4'hA: cond_d = !l_f && !z_f;
            4'hB: cond_d = l_f || z_f;
            4'hC: cond_d = !n_f && !z_f;
            4'hD: cond_d = n_f || z_f;
            4'hE: cond_d = 1'b1;
            default: cond_d = 1'b0;
        endcase
    end

    always_comb begin
        case (INT_SIZE)
            SIZE_BYTE:   iw_d = WIDTH_8;
            SIZE_WORD:   iw_d = WIDTH_16;
            SIZE_DOUBLE: iw_d = WIDTH_32;
            default:     iw_d = WIDTH_32;
        endcase
        fw_d = FLOAT_TYPE ? WIDTH_32 : WIDTH_64;
        cw_d = CUSTOM_TYPE ? WIDTH_32 : WIDTH_64;
        // Quick value extended to the operand size; upper bits zero beyond it
        case (iw_d)
            WIDTH_8:  quick_d = {24'h000000, {4{SHORT_FIELD[3]}}, SHORT_FIELD};
            WIDTH_16: quick_d = {16'h0000, {12{SHORT_FIELD[3]}}, SHORT_FIELD};
            default:  quick_d = {{28{SHORT_FIELD[3]}}, SHORT_FIELD};
        endcase
    end

    always_comb begin
        role_d = ROLE_QUICK;
        sel_d  = 4'h0;
        rsvd_d = 1'b0;
        trap_d = 1'b0;
        case (INSTR_GROUP)
            GRP_SETCOND: role_d = ROLE_COND;
            GRP_PREG: begin
                role_d = ROLE_AREG;
                sel_d  = SHORT_FIELD;
                case (SHORT_FIELD)
                    AREG_ALT_SP, AREG_FRAME, AREG_STACK, AREG_STATIC,
                    AREG_STATUS, AREG_INTTAB, AREG_LINK: rsvd_d = 1'b0;
                    default: rsvd_d = 1'b1;
                endcase
            end
            GRP_MREG: begin
                role_d = ROLE_AREG;
                sel_d  = SHORT_FIELD;
                case (SHORT_FIELD)
                    MREG_BRK0, MREG_BRK1, MREG_STATUS, MREG_BCOUNT,
                    MREG_PTR0, MREG_PTR1, MREG_ERRADR: rsvd_d = 1'b0;
                    default: rsvd_d = 1'b1;
                endcase
            end
            GRP_JUMP:   trap_d = INSTR_OPCODE[0] || (INSTR_OPCODE == JUMP_BAD);
            GRP_STRING: trap_d = INSTR_OPCODE[3] || (INSTR_OPCODE[3:2] == 2'h1);
            default: ;
        endcase
        trap_d  = trap_d && INSTR_VALID;
        valid_d = INSTR_VALID;
    end

    // Register port: status clears on read, but a new event in the same cycle wins
    always_comb begin
        stat_d = stat_q;
        if (REG_RD && REG_ADDR == REG_STATUS)
            stat_d = 2'h0;
        if (trap_q)
            stat_d[EVT_TRAP] = 1'b1;
        if (valid_q && rsvd_q)
            stat_d[EVT_RSVD] = 1'b1;
        mask_d = (REG_WR && REG_ADDR == REG_MASK) ? REG_WDATA[1:0] : mask_q;
        cnt_d  = (REG_WR && REG_ADDR == REG_COUNT) ? REG_WDATA[15:0] : cnt_q + 16'(trap_q);
        case (REG_ADDR)
            REG_STATUS: rdata_d = {30'h0, stat_q};
            REG_MASK:   rdata_d = {30'h0, mask_q};
            REG_COUNT:  rdata_d = {16'h0, cnt_q};
            default:    rdata_d = 32'h0;
        endcase
        if (!REG_RD)
            rdata_d = 32'h0;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cond_q  <= 1'b0;
            trap_q  <= 1'b0;
            rsvd_q  <= 1'b0;
            iw_q    <= WIDTH_8;
            fw_q    <= WIDTH_8;
            cw_q    <= WIDTH_8;
            role_q  <= ROLE_QUICK;
            quick_q <= 32'h0;
            sel_q   <= 4'h0;
            valid_q <= 1'b0;
            stat_q  <= EVT_RESET;
            mask_q  <= MASK_RESET;
            cnt_q   <= 16'h0;
            rdata_q <= 32'h0;
        end else begin
            cond_q  <= cond_d;
            trap_q  <= trap_d;
            rsvd_q  <= rsvd_d;
            iw_q    <= iw_d;
            fw_q    <= fw_d;
            cw_q    <= cw_d;
            role_q  <= role_d;
            quick_q <= quick_d;
            sel_q   <= sel_d;
            valid_q <= valid_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            cnt_q   <= cnt_d;
            rdata_q <= rdata_d;
        end
    end

    assign DEC_VALID           = valid_q;
    // Execution is withheld in the same cycle the trap is flagged, so no operand is touched
    assign EXEC_ENABLE         = valid_q && !trap_q;
    assign ILLEGAL_OPCODE_TRAP = trap_q;
    assign INT_WIDTH           = iw_q;
    assign FLOAT_WIDTH         = fw_q;
    assign CUSTOM_WIDTH        = cw_q;
    assign COND_TRUE           = cond_q;
    assign SHORT_ROLE          = role_q;
    assign QUICK_VALUE         = quick_q;
    assign REG_SELECT          = sel_q;
    assign REG_RESERVED        = rsvd_q;
    assign REG_RDATA           = rdata_q;
    assign IRQ                 = |(stat_q & mask_q);

    // The edge that releases reset still clears the flops, so antecedents also need RST_N sampled high
    a_cond_always: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hE |=> COND_TRUE)
        else $error("always-true code not true");
    a_cond_never: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hF |=> !COND_TRUE)
        else $error("always-false code true");
    a_cond_lower: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hA |=> COND_TRUE == (!$past(l_f) && !$past(z_f)))
        else $error("lower wrong");
    a_cond_higher: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hB |=> COND_TRUE == ($past(l_f) || $past(z_f)))
        else $error("higher or same wrong");
    a_cond_less: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hC |=> COND_TRUE == (!$past(n_f) && !$past(z_f)))
        else $error("less than wrong");
    a_cond_greater: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'hD |=> COND_TRUE == ($past(n_f) || $past(z_f)))
        else $error("greater or equal wrong");
    a_cond_equal: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'h0 |=> COND_TRUE == $past(z_f))
        else $error("equal wrong");
    a_cond_carry: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'h2 |=> COND_TRUE == $past(c_f))
        else $error("carry set wrong");
    a_cond_flag_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && cond_sel == 4'h9 |=> COND_TRUE == !$past(g_f))
        else $error("flag clear wrong");
    a_size_double: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_DOUBLE |=> INT_WIDTH == WIDTH_32)
        else $error("double size wrong");
    a_size_byte: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_BYTE |=> INT_WIDTH == WIDTH_8)
        else $error("byte size wrong");
    a_size_word: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_WORD |=> INT_WIDTH == WIDTH_16)
        else $error("word size wrong");
    a_float_width: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N |=> FLOAT_WIDTH == ($past(FLOAT_TYPE) ? WIDTH_32 : WIDTH_64))
        else $error("float width");
    a_custom_width: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && !CUSTOM_TYPE |=> CUSTOM_WIDTH == WIDTH_64)
        else $error("custom width");
    a_custom_double: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && CUSTOM_TYPE |=> CUSTOM_WIDTH == WIDTH_32)
        else $error("custom double width");
    a_quick_sign: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_DOUBLE && SHORT_FIELD == 4'hF |=> QUICK_VALUE == 32'hFFFFFFFF)
        else $error("quick sign");
    a_quick_byte: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_BYTE && SHORT_FIELD == 4'h8 |=> QUICK_VALUE == 32'h000000F8)
        else $error("quick byte extension");
    a_quick_word: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INT_SIZE == SIZE_WORD && SHORT_FIELD == 4'h8 |=> QUICK_VALUE == 32'h0000FFF8)
        else $error("quick word extension");
    a_quick_positive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && !SHORT_FIELD[3] |=> QUICK_VALUE == {28'h0000000, $past(SHORT_FIELD)})
        else $error("quick positive value");
    a_quick_role: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_QUICK |=> SHORT_ROLE == ROLE_QUICK)
        else $error("quick role");
    a_setcond_role: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_SETCOND |=> SHORT_ROLE == ROLE_COND)
        else $error("role");
    a_areg_rsvd: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_PREG && SHORT_FIELD == 4'hB |=> REG_RESERVED && SHORT_ROLE == ROLE_AREG)
        else $error("reserved areg");
    a_areg_map: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_PREG && SHORT_FIELD == AREG_STATUS |=> !REG_RESERVED && REG_SELECT == AREG_STATUS)
        else $error("status areg");
    a_mreg_ok: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_MREG && SHORT_FIELD == MREG_ERRADR |=> !REG_RESERVED)
        else $error("mreg");
    a_mreg_rsvd: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_GROUP == GRP_MREG && SHORT_FIELD == 4'hE |=> REG_RESERVED && SHORT_ROLE == ROLE_AREG)
        else $error("reserved mreg");
    a_jump_trap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_VALID && INSTR_GROUP == GRP_JUMP && INSTR_OPCODE[0] |=> ILLEGAL_OPCODE_TRAP)
        else $error("jump trap missed");
    a_jump_bad: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_VALID && INSTR_GROUP == GRP_JUMP && INSTR_OPCODE == JUMP_BAD |=> ILLEGAL_OPCODE_TRAP)
        else $error("jump opcode eight missed");
    a_jump_ok: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_VALID && INSTR_GROUP == GRP_JUMP && !INSTR_OPCODE[0] && INSTR_OPCODE != JUMP_BAD
        |=> !ILLEGAL_OPCODE_TRAP) else $error("valid jump trapped");
    a_string_ok: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && INSTR_VALID && INSTR_GROUP == GRP_STRING |=> ILLEGAL_OPCODE_TRAP == ($past(INSTR_OPCODE) > 4'h3))
        else $error("string trap wrong");
    a_trap_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ILLEGAL_OPCODE_TRAP |-> !EXEC_ENABLE)
        else $error("trapped op executed");
    a_trap_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && !INSTR_VALID |=> !ILLEGAL_OPCODE_TRAP && !EXEC_ENABLE)
        else $error("idle cycle trapped or executed");
    // Register port and interrupt state
    a_trap_status: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && ILLEGAL_OPCODE_TRAP |=> stat_q[EVT_TRAP])
        else $error("trap not recorded");
    a_status_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && stat_q[EVT_TRAP] && !(REG_RD && REG_ADDR == REG_STATUS) |=> stat_q[EVT_TRAP])
        else $error("trap status lost");
    a_count_trap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && ILLEGAL_OPCODE_TRAP && !(REG_WR && REG_ADDR == REG_COUNT) |=> cnt_q == $past(cnt_q) + 16'h1)
        else $error("trap count not advanced");
    a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && !REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data without read");
    a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RST_N && REG_RD && REG_ADDR == 2'h3 |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    c_trap: cover property (@(posedge CLK_SYS) disable iff (!RST_N) ILLEGAL_OPCODE_TRAP);
    c_exec: cover property (@(posedge CLK_SYS) disable iff (!RST_N) EXEC_ENABLE && COND_TRUE);
    c_irq:  cover property (@(posedge CLK_SYS) disable iff (!RST_N) IRQ);
    c_rsvd: cover property (@(posedge CLK_SYS) disable iff (!RST_N) DEC_VALID && REG_RESERVED);
    c_neg:  cover property (@(posedge CLK_SYS) disable iff (!RST_N) DEC_VALID && QUICK_VALUE[31]);

endmodule : ofd_decoder

// >>> hdl/ofd_pkg.sv
// Constants and types for the opcode field decoder
// Operation
// - size field 00 byte, 01 word, 11 double
// - float type 1 is 32-bit, 0 is 64-bit
// - custom type 1 double word, 0 quad word
// - codes 0000-1001 test one flag, paired
// - codes 1010-1101 combine two flags
// - code 1110 always true, 1111 always false
// - quick value is signed 4-bit, sign-extended
// - short field is condition or dedicated register
// - dedicated register selector map, rest reserved
// - translation register selector map, rest reserved
// - jump group traps on XXX1 and 1000
// - string group traps on 1XXX and 01XX
package ofd_pkg;
    localparam logic [1:0] SIZE_BYTE   = 2'h0;
    localparam logic [1:0] SIZE_WORD   = 2'h1;
    localparam logic [1:0] SIZE_DOUBLE = 2'h3;
    localparam logic [1:0] WIDTH_8     = 2'h0;
    localparam logic [1:0] WIDTH_16    = 2'h1;
    localparam logic [1:0] WIDTH_32    = 2'h2;
    localparam logic [1:0] WIDTH_64    = 2'h3;
    // Role of the short field
    localparam logic [1:0] ROLE_QUICK  = 2'h0;
    localparam logic [1:0] ROLE_COND   = 2'h1;
    localparam logic [1:0] ROLE_AREG   = 2'h2;
    // Opcode groups presented by the prefetch path
    localparam logic [2:0] GRP_NONE    = 3'h0;
    localparam logic [2:0] GRP_QUICK   = 3'h1;
    localparam logic [2:0] GRP_SETCOND = 3'h2;
    localparam logic [2:0] GRP_PREG    = 3'h3;
    localparam logic [2:0] GRP_MREG    = 3'h4;
    localparam logic [2:0] GRP_JUMP    = 3'h5;
    localparam logic [2:0] GRP_STRING  = 3'h6;
    // Dedicated register selector codes
    localparam logic [3:0] AREG_ALT_SP = 4'h0;
    localparam logic [3:0] AREG_FRAME  = 4'h8;
    localparam logic [3:0] AREG_STACK  = 4'h9;
    localparam logic [3:0] AREG_STATIC = 4'hA;
    localparam logic [3:0] AREG_STATUS = 4'hD;
    localparam logic [3:0] AREG_INTTAB = 4'hE;
    localparam logic [3:0] AREG_LINK   = 4'hF;
    // Translation register selector codes
    localparam logic [3:0] MREG_BRK0   = 4'h0;
    localparam logic [3:0] MREG_BRK1   = 4'h1;
    localparam logic [3:0] MREG_STATUS = 4'hA;
    localparam logic [3:0] MREG_BCOUNT = 4'hB;
    localparam logic [3:0] MREG_PTR0   = 4'hC;
    localparam logic [3:0] MREG_PTR1   = 4'hD;
    localparam logic [3:0] MREG_ERRADR = 4'hF;
    localparam logic [3:0] JUMP_BAD    = 4'h8;
    // Register port map and interrupt bits
    localparam logic [1:0] REG_STATUS  = 2'h0;
    localparam logic [1:0] REG_MASK    = 2'h1;
    localparam logic [1:0] REG_COUNT   = 2'h2;
    localparam int         EVT_TRAP    = 0;
    localparam int         EVT_RSVD    = 1;
    localparam logic [1:0] EVT_RESET   = 2'h0;
    localparam logic [1:0] MASK_RESET  = 2'h0;
endpackage : ofd_pkg

// >>> test/ofd_prefetch_model.sv
// Prefetch path model that presents one instruction word per bench request
`timescale 1ns/1ps
module ofd_prefetch_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Request from the bench
    input  wire logic        push,
    input  wire logic [23:0] fields,
    // Fields toward the decoder
    output logic             valid,
    output logic [23:0]      bus
);
    // Idle cycles show a word that changes every cycle, so stale fields never pass as live ones
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid <= 1'b0;
            bus   <= 24'h000000;
        end else if (push) begin
            valid <= 1'b1;
            bus   <= fields;
        end else begin
            valid <= 1'b0;
            bus   <= ~bus;
        end
    end
endmodule : ofd_prefetch_model

// >>> test/ofd_decoder_tb_top.sv
// Self-checking bench for the opcode field decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module ofd_decoder_tb_top
    import ofd_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, push = 1'b0, valid, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [23:0] fields = 24'h000000, bus;
    logic [1:0] reg_addr = 2'h0, int_w, flt_w, cst_w, role;
    logic [31:0] reg_wdata = 32'h00000000, rdata, qv, rd;
    logic [3:0] sel;
    logic dv, ex, ct, rsv, trap, irq, t;
    int fail_count = 0, comparisons = 0, cycles = 0, ntrap = 0;
    logic [1:0] szt[3] = '{SIZE_BYTE, SIZE_WORD, SIZE_DOUBLE};
    logic [1:0] wdt[3] = '{WIDTH_8, WIDTH_16, WIDTH_32};

    always #2.5 clk_sys = ~clk_sys;

    ofd_prefetch_model u_src (.clk(clk_sys), .rst_n(rst_n), .push(push), .fields(fields), .valid(valid), .bus(bus));
    ofd_decoder u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .INSTR_VALID(valid), .INSTR_GROUP(bus[23:21]),
        .INSTR_OPCODE(bus[20:17]), .SHORT_FIELD(bus[16:13]), .COND_FIELD(bus[12:9]), .INT_SIZE(bus[8:7]),
        .FLOAT_TYPE(bus[6]), .CUSTOM_TYPE(bus[5]), .FLAGS_ZCLNF(bus[4:0]), .DEC_VALID(dv), .EXEC_ENABLE(ex),
        .INT_WIDTH(int_w), .FLOAT_WIDTH(flt_w), .CUSTOM_WIDTH(cst_w), .COND_TRUE(ct), .SHORT_ROLE(role),
        .QUICK_VALUE(qv), .REG_SELECT(sel), .REG_RESERVED(rsv), .ILLEGAL_OPCODE_TRAP(trap),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .IRQ(irq));

    function automatic logic [23:0] mk(input logic [2:0] g, input logic [3:0] op, input logic [3:0] sh,
        input logic [3:0] cd, input logic [1:0] sz, input logic ft, input logic [4:0] fl);
        return {g, op, sh, cd, sz, ft, ft, fl};
    endfunction : mk

    // Flags are {Z,C,L,N,F}; odd codes are the inverse of the even code below them
    function automatic logic cond_exp(input logic [3:0] c, input logic [4:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[4];
            3'h1: r = f[3];
            3'h2: r = f[2];
            3'h3: r = f[1];
            3'h4: r = f[0];
            3'h5: r = !(f[2] | f[4]);
            3'h6: r = !(f[1] | f[4]);
            default: r = 1'b1;
        endcase
        return r ^ c[0];
    endfunction : cond_exp

    task automatic issue(input logic [23:0] f);
        @(posedge clk_sys);
        push   <= 1'b1;
        fields <= f;
        @(posedge clk_sys);
        push   <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : issue

    task automatic reg_access(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd = rdata;
    endtask : reg_access

    task automatic final_report();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_access(1'b0, REG_MASK, 32'h0);
        `CHK("mask reset", 32'h0, rd)
        for (int i = 0; i < 3; i++) begin
            for (int f = 0; f < 2; f++) begin
                issue(mk(GRP_NONE, 4'h0, 4'h0, 4'h0, szt[i], f[0], 5'h00));
                `CHK("int width", wdt[i], int_w)
                `CHK("float width", f[0] ? WIDTH_32 : WIDTH_64, flt_w)
                `CHK("custom width", f[0] ? WIDTH_32 : WIDTH_64, cst_w)
                `CHK("dec valid", 1'b1, dv)
            end
        end
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 64; f++) begin
                issue(mk(f[5] ? GRP_SETCOND : GRP_NONE, 4'h0, f[5] ? 4'(c) : ~4'(c), f[5] ? ~4'(c) : 4'(c),
                    SIZE_BYTE, 1'b0, 5'(f)));
                `CHK("condition", cond_exp(4'(c), 5'(f)), ct)
                if (f[5]) `CHK("cond role", ROLE_COND, role)
            end
        end
        for (int s = 0; s < 16; s++) begin
            for (int i = 0; i < 3; i++) begin
                issue(mk(GRP_QUICK, 4'h0, 4'(s), 4'h0, szt[i], 1'b0, 5'h00));
                rd = {{28{s[3]}}, s[3:0]};
                rd = (i == 0) ? {24'h0, rd[7:0]} : (i == 1) ? {16'h0, rd[15:0]} : rd;
                `CHK("quick value", rd, qv)
                `CHK("quick role", ROLE_QUICK, role)
            end
            for (int g = 0; g < 2; g++) begin
                issue(mk(g ? GRP_MREG : GRP_PREG, 4'h0, 4'(s), 4'h0, SIZE_BYTE, 1'b0, 5'h00));
                t = 1'((g ? 16'h43FC : 16'h18FE) >> s);
                `CHK("selector", 4'(s), sel)
                `CHK("reserved", t, rsv)
                `CHK("areg role", ROLE_AREG, role)
                `CHK("reserved runs", 1'b1, ex)
            end
        end
        `CHK("irq masked", 1'b0, irq)
        reg_access(1'b0, REG_STATUS, 32'h0);
        `CHK("status sel", 32'h2, rd)
        reg_access(1'b0, REG_STATUS, 32'h0);
        `CHK("status clear", 32'h0, rd)
        reg_access(1'b1, REG_MASK, 32'h1);
        for (int op = 0; op < 32; op++) begin
            issue(mk(op[4] ? GRP_STRING : GRP_JUMP, 4'(op), 4'h0, 4'h0, SIZE_BYTE, 1'b0, 5'h00));
            t = op[4] ? (op[3:0] > 3) : (op[0] || op[3:0] == 8);
            ntrap += t;
            `CHK("trap", t, trap)
            `CHK("exec", !t, ex)
        end
        @(posedge clk_sys);
        #1;
        `CHK("irq", 1'b1, irq)
        reg_access(1'b0, REG_COUNT, 32'h0);
        `CHK("trap count", 32'(ntrap), rd)
        reg_access(1'b0, REG_STATUS, 32'h0);
        `CHK("status trap", 32'h1, rd)
        `CHK("irq cleared", 1'b0, irq)
        reg_access(1'b1, 2'h3, 32'hFFFFFFFF);
        reg_access(1'b0, 2'h3, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        reg_access(1'b1, REG_MASK, 32'h3);
        reg_access(1'b0, REG_MASK, 32'h0);
        `CHK("mask rw", 32'h3, rd)
        reg_access(1'b1, REG_COUNT, 32'h1234);
        reg_access(1'b0, REG_COUNT, 32'h0);
        `CHK("count rw", 32'h1234, rd)
        `CHK("dec idle", 1'b0, dv)
        final_report();
    end
endmodule : ofd_decoder_tb_top
